// ==== rtcal_pkg.sv ====
// Constants, register map and state type for the alarm comparator block
// Assumes one 100 MHz clock and a two-wire serial link sampled as pins

package rtcal_pkg;

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [7:0] ADDR_SECOND = 8'h00;
	localparam logic [7:0] ADDR_MINUTE = 8'h01;
	localparam logic [7:0] ADDR_HOUR = 8'h02;
	localparam logic [7:0] ADDR_DATE = 8'h03;
	localparam logic [7:0] ADDR_MONTH = 8'h04;
	localparam logic [7:0] ADDR_WEEKDAY = 8'h05;
	localparam logic [7:0] ADDR_STATUS = 8'h07;
	localparam logic [7:0] ADDR_INTCTL = 8'h08;
	localparam logic [7:0] ADDR_ALARM_FIRST = 8'h0c;
	localparam logic [7:0] ADDR_ALARM_LAST = 8'h14;
	localparam logic [7:0] ADDR_PTR_LAST = 8'h1f;
	localparam logic [7:0] ADDR_PTR_FIRST = 8'h00;

	// ************************************************************
	// Alarm byte indices and field layout
	// ************************************************************
	localparam int NUM_ALARM_REGS = 9;
	localparam int NUM_A1_FIELDS = 6;
	localparam int A2_MINUTE_IDX = 6;
	localparam int A2_HOUR_IDX = 7;
	localparam int A2_DAYDATE_IDX = 8;
	localparam int ENABLE_BIT = 7;
	localparam int DAYSEL_BIT = 6;
	// Compare masks per alarm-one field; hour keeps its format bit
	localparam logic [6:0] A1_FIELD_MASK [NUM_A1_FIELDS] = '{
		7'h7f, 7'h7f, 7'h7f, 7'h3f, 7'h1f, 7'h07};
	localparam logic [5:0] DATE_MASK = 6'h3f;
	localparam logic [5:0] WEEKDAY_MASK = 6'h07;
	localparam logic [6:0] SECOND_ZERO = 7'h00;
	localparam logic [7:0] ALARM_RESET = 8'h00;

	// ************************************************************
	// Status and interrupt control fields
	// ************************************************************
	localparam int ST_AUTOCLR_BIT = 7;
	localparam int ST_A1F_BIT = 2;
	localparam int ST_A2F_BIT = 1;
	localparam int IC_FIRST_ALARM_FUNCTION_ON_BIT = 6;
	localparam int IC_SECOND_ALARM_FUNCTION_ON_BIT = 5;
	localparam int IC_FO_HI_BIT = 4;
	localparam int IC_FO_LO_BIT = 3;
	localparam int IC_PIN_INTERRUPT_SELECT_BIT = 2;
	localparam int IC_A1E_BIT = 0;
	localparam logic [7:0] INTCTL_RESET = 8'h18;
	localparam logic [7:0] INTCTL_WMASK = 8'h7d;

	// ************************************************************
	// Link and timing
	// ************************************************************
	localparam logic [6:0] DEVICE_ID = 7'h6f;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int CLK_PERIOD_NS = 10;
	localparam int POWERUP_NS = 1000;
	localparam int POWERUP_CYCLES =
		(POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Serial interface states
	typedef enum logic [2:0] {
		ST_IDLE, ST_DEV, ST_REG, ST_WR, ST_RD
	} rtcal_state_type;

endpackage : rtcal_pkg

// ==== rtcal_slave.sv ====
// Alarm comparators with the two-wire slave port that reaches them
// Assumes clock fields and their update strobe arrive on mclk; the
// serial pins are asynchronous and are resynchronised here
`timescale 1ns/100ps
`default_nettype none

module rtcal_slave #(
	parameter logic [6:0] DEV_ID = rtcal_pkg::DEVICE_ID,
	parameter int POWERUP_CYCLES = rtcal_pkg::POWERUP_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic interrupt_or_clock_out_pin_out,
	output logic interrupt_or_clock_out_pin_oe_n,
	input wire logic time_tick,
	input wire logic [7:0] time_second,
	input wire logic [7:0] time_minute,
	input wire logic [7:0] time_hour,
	input wire logic [7:0] time_date,
	input wire logic [7:0] time_month,
	input wire logic [7:0] time_weekday,
	output logic first_alarm_flag,
	output logic second_alarm_flag
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (POWERUP_CYCLES < 1 || POWERUP_CYCLES > 65535) begin : g_chk
		$error("POWERUP_CYCLES out of range");
	end

	localparam int PW = $clog2(POWERUP_CYCLES + 1);
	localparam logic [PW-1:0] PWR_DONE = PW'(POWERUP_CYCLES);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic scl_meta_q, scl_sync_q, scl_prev_q; // Clock pin synchroniser
	logic sda_meta_q, sda_sync_q, sda_prev_q; // Data pin synchroniser
	logic [PW-1:0] pwr_cnt_q; // Power-up hold-off counter
	rtcal_pkg::rtcal_state_type state_q; // Serial interface state
	logic [3:0] bit_q; // Bits of the current byte seen
	logic ack_phase_q; // Inside the ninth clock
	logic [7:0] shift_q; // Receive and transmit shifter
	logic drive_q; // Pull the data line low
	logic rw_q; // Identifier asked for a read
	logic [7:0] ptr_q; // Register pointer
	logic status_read_q; // Status byte sent in this transfer
	logic autoclr_q; // flag_auto_clear
	logic first_alarm_flag_q, second_alarm_flag_q;
	logic [7:0] intctl_q; // Interrupt control byte
	logic [7:0] alarm_q [rtcal_pkg::NUM_ALARM_REGS]; // Alarm bytes
	logic a1_prev_q, a2_prev_q; // Match seen at last evaluation
	logic first_alarm_flag_d, second_alarm_flag_d;

	// ************************************************************
	// Pin synchronisers and line events
	// ************************************************************
	// Two stages before any logic looks at the asynchronous pins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scl_meta_q <= 1'b1;
			scl_sync_q <= 1'b1;
			scl_prev_q <= 1'b1;
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_meta_q <= scl_in;
			scl_sync_q <= scl_meta_q;
			scl_prev_q <= scl_sync_q;
			sda_meta_q <= sda_in;
			sda_sync_q <= sda_meta_q;
			sda_prev_q <= sda_sync_q;
		end
	end

	wire scl_rise = scl_sync_q && !scl_prev_q;
	wire scl_fall = !scl_sync_q && scl_prev_q;
	// Data moving while the clock stays high marks START or STOP
	wire scl_high = scl_sync_q && scl_prev_q;
	wire start_det = scl_high && sda_prev_q && !sda_sync_q;
	wire stop_det = scl_high && !sda_prev_q && sda_sync_q;

	// ************************************************************
	// Power-up hold-off
	// ************************************************************
	// START is ignored until the counter saturates
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pwr_cnt_q <= '0;
		end else if (pwr_cnt_q != PWR_DONE) begin
			pwr_cnt_q <= pwr_cnt_q + PW'(1);
		end
	end

	wire powered = (pwr_cnt_q == PWR_DONE);
	wire start_go = start_det && powered;

	// ************************************************************
	// Byte decode and register read selection
	// ************************************************************
	wire byte_done = scl_fall && !ack_phase_q &&
		bit_q == rtcal_pkg::BITS_PER_BYTE;
	wire ack_done = scl_fall && ack_phase_q;
	wire id_match = shift_q[7:1] == DEV_ID;
	wire [7:0] ptr_next = (ptr_q == rtcal_pkg::ADDR_PTR_LAST) ?
		rtcal_pkg::ADDR_PTR_FIRST : ptr_q + 8'h01;
	wire in_alarm = ptr_q >= rtcal_pkg::ADDR_ALARM_FIRST &&
		ptr_q <= rtcal_pkg::ADDR_ALARM_LAST;
	wire [3:0] alarm_idx = 4'(ptr_q - rtcal_pkg::ADDR_ALARM_FIRST);
	// Write strobe lands as the device starts the acknowledge
	wire wr_go = byte_done && state_q == rtcal_pkg::ST_WR;
	wire wr_status = wr_go && ptr_q == rtcal_pkg::ADDR_STATUS;
	wire wr_intctl = wr_go && ptr_q == rtcal_pkg::ADDR_INTCTL;
	// Next transmit byte is fetched at the end of an acknowledge; a
	// master NACK fetches nothing, so the pointer and the status-read
	// marker only see bytes that really go out
	wire rd_load = ack_done && ((state_q == rtcal_pkg::ST_RD &&
		!sda_sync_q) || (state_q == rtcal_pkg::ST_DEV && rw_q));

	logic [7:0] status_byte; // Assembled status register
	always_comb begin
		status_byte = '0;
		status_byte[rtcal_pkg::ST_AUTOCLR_BIT] = autoclr_q;
		status_byte[rtcal_pkg::ST_A1F_BIT] = first_alarm_flag_q;
		status_byte[rtcal_pkg::ST_A2F_BIT] = second_alarm_flag_q;
	end

	// Unmapped and unmodelled addresses read as zero
	wire [7:0] rd_byte =
		(ptr_q == rtcal_pkg::ADDR_SECOND) ? time_second :
		(ptr_q == rtcal_pkg::ADDR_MINUTE) ? time_minute :
		(ptr_q == rtcal_pkg::ADDR_HOUR) ? time_hour :
		(ptr_q == rtcal_pkg::ADDR_DATE) ? time_date :
		(ptr_q == rtcal_pkg::ADDR_MONTH) ? time_month :
		(ptr_q == rtcal_pkg::ADDR_WEEKDAY) ? time_weekday :
		(ptr_q == rtcal_pkg::ADDR_STATUS) ? status_byte :
		(ptr_q == rtcal_pkg::ADDR_INTCTL) ? intctl_q :
		in_alarm ? alarm_q[alarm_idx] : 8'h00;

	// ************************************************************
	// Serial slave state machine
	// ************************************************************
	// Samples on the clock rise, moves the data line after the fall,
	// so the line never changes while the master holds clock high
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= rtcal_pkg::ST_IDLE;
			bit_q <= '0;
			ack_phase_q <= 1'b0;
			shift_q <= '0;
			drive_q <= 1'b0;
			rw_q <= 1'b0;
		end else if (start_go) begin
			// Repeated START restarts identification
			state_q <= rtcal_pkg::ST_DEV;
			bit_q <= '0;
			ack_phase_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (stop_det) begin
			state_q <= rtcal_pkg::ST_IDLE;
			drive_q <= 1'b0;
			ack_phase_q <= 1'b0;
		end else if (state_q != rtcal_pkg::ST_IDLE) begin
			if (scl_rise && !ack_phase_q) begin
				// Master clocks every bit; MSB arrives first
				bit_q <= bit_q + 4'h1;
				if (state_q != rtcal_pkg::ST_RD) begin
					shift_q <= {shift_q[6:0], sda_sync_q};
				end
			end else if (byte_done) begin
				ack_phase_q <= 1'b1;
				bit_q <= '0;
				case (state_q)
					rtcal_pkg::ST_DEV: begin
						// Foreign identifier: stay off the line
						drive_q <= id_match;
						rw_q <= shift_q[0];
						if (!id_match) begin
							state_q <= rtcal_pkg::ST_IDLE;
						end
					end
					rtcal_pkg::ST_RD: begin
						drive_q <= 1'b0;
					end
					default: begin
						drive_q <= 1'b1;
					end
				endcase
			end else if (ack_done) begin
				ack_phase_q <= 1'b0;
				case (state_q)
					rtcal_pkg::ST_DEV: begin
						state_q <= rw_q ? rtcal_pkg::ST_RD : rtcal_pkg::ST_REG;
						shift_q <= rd_byte;
						drive_q <= rw_q && !rd_byte[7];
					end
					rtcal_pkg::ST_REG: begin
						state_q <= rtcal_pkg::ST_WR;
						drive_q <= 1'b0;
					end
					rtcal_pkg::ST_RD: begin
						// Without the master's acknowledge, wait for STOP
						if (sda_sync_q) begin
							state_q <= rtcal_pkg::ST_IDLE;
							drive_q <= 1'b0;
						end else begin
							shift_q <= rd_byte;
							drive_q <= !rd_byte[7];
						end
					end
					default: begin
						drive_q <= 1'b0;
					end
				endcase
			end else if (scl_fall && state_q == rtcal_pkg::ST_RD) begin
				// Present the next bit while the clock is low
				shift_q <= {shift_q[6:0], 1'b0};
				drive_q <= !shift_q[6];
			end
		end
	end

	// ************************************************************
	// Register pointer and status-read tracking
	// ************************************************************
	// Pointer moves after each written byte and each fetched byte
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ptr_q <= rtcal_pkg::ADDR_PTR_FIRST;
			status_read_q <= 1'b0;
		end else begin
			if (byte_done && state_q == rtcal_pkg::ST_REG) begin
				ptr_q <= shift_q;
			end else if (wr_go || rd_load) begin
				ptr_q <= ptr_next;
			end
			// Only a read that ends in STOP may auto-clear
			if (stop_det || start_go && state_q == rtcal_pkg::ST_IDLE) begin
				status_read_q <= 1'b0;
			end else if (rd_load && ptr_q == rtcal_pkg::ADDR_STATUS) begin
				status_read_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Control and alarm registers
	// ************************************************************
	// Clock registers are read-only here; their writes are dropped
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			autoclr_q <= 1'b0;
			intctl_q <= rtcal_pkg::INTCTL_RESET;
			for (int i = 0; i < rtcal_pkg::NUM_ALARM_REGS; i++) begin
				alarm_q[i] <= rtcal_pkg::ALARM_RESET;
			end
		end else begin
			if (wr_status) begin
				autoclr_q <= shift_q[rtcal_pkg::ST_AUTOCLR_BIT];
			end
			if (wr_intctl) begin
				intctl_q <= shift_q & rtcal_pkg::INTCTL_WMASK;
			end
			if (wr_go && in_alarm) begin
				alarm_q[alarm_idx] <= shift_q;
			end
		end
	end

	// ************************************************************
	// Alarm one comparator
	// ************************************************************
	wire [6:0] a1_time [rtcal_pkg::NUM_A1_FIELDS];
	assign a1_time[0] = time_second[6:0];
	assign a1_time[1] = time_minute[6:0];
	assign a1_time[2] = time_hour[6:0];
	assign a1_time[3] = time_date[6:0];
	assign a1_time[4] = time_month[6:0];
	assign a1_time[5] = time_weekday[6:0];

	logic [rtcal_pkg::NUM_A1_FIELDS-1:0] a1_en, a1_hit;
	// Hour mask keeps the format bit, so mixed formats never match
	for (genvar g = 0; g < rtcal_pkg::NUM_A1_FIELDS; g++) begin : g_a1
		assign a1_en[g] = alarm_q[g][rtcal_pkg::ENABLE_BIT];
		assign a1_hit[g] = !a1_en[g] ||
			((alarm_q[g][6:0] & rtcal_pkg::A1_FIELD_MASK[g]) ==
			(a1_time[g] & rtcal_pkg::A1_FIELD_MASK[g]));
	end

	wire alm1_on = intctl_q[rtcal_pkg::IC_FIRST_ALARM_FUNCTION_ON_BIT];
	wire a1_match = alm1_on && &a1_hit;
	// Each update is a second; all fields off fires every update
	wire a1_fire = time_tick && a1_match &&
		(a1_en == '0 || !a1_prev_q);

	// ************************************************************
	// Alarm two comparator
	// ************************************************************
	wire [7:0] a2_dd = alarm_q[rtcal_pkg::A2_DAYDATE_IDX];
	wire a2_daysel = a2_dd[rtcal_pkg::DAYSEL_BIT];
	wire [5:0] a2_dd_mask = a2_daysel ?
		rtcal_pkg::WEEKDAY_MASK : rtcal_pkg::DATE_MASK;
	wire [5:0] a2_dd_time = a2_daysel ?
		time_weekday[5:0] : time_date[5:0];
	wire [2:0] a2_en = {a2_dd[rtcal_pkg::ENABLE_BIT],
		alarm_q[rtcal_pkg::A2_HOUR_IDX][rtcal_pkg::ENABLE_BIT],
		alarm_q[rtcal_pkg::A2_MINUTE_IDX][rtcal_pkg::ENABLE_BIT]};
	wire a2_hit_min = !a2_en[0] ||
		alarm_q[rtcal_pkg::A2_MINUTE_IDX][6:0] == time_minute[6:0];
	wire a2_hit_hour = !a2_en[1] ||
		alarm_q[rtcal_pkg::A2_HOUR_IDX][6:0] == time_hour[6:0];
	wire a2_hit_dd = !a2_en[2] ||
		(a2_dd[5:0] & a2_dd_mask) == (a2_dd_time & a2_dd_mask);
	wire a2_match = intctl_q[rtcal_pkg::IC_SECOND_ALARM_FUNCTION_ON_BIT] &&
		a2_hit_min && a2_hit_hour && a2_hit_dd;
	// Alarm two is only looked at as seconds reach zero
	wire a2_eval = time_tick && time_second[6:0] == rtcal_pkg::SECOND_ZERO;
	wire a2_fire = a2_eval && a2_match &&
		(a2_en == '0 || !a2_prev_q);

	// ************************************************************
	// Alarm flags
	// ************************************************************
	wire auto_clear = stop_det && status_read_q && autoclr_q;
	wire clr_a1 = wr_status && !shift_q[rtcal_pkg::ST_A1F_BIT];
	wire clr_a2 = wr_status && !shift_q[rtcal_pkg::ST_A2F_BIT];
	// A match in the clearing cycle wins over the clear
	assign first_alarm_flag_d = a1_fire ||
		(first_alarm_flag_q && !clr_a1 && !auto_clear);
	assign second_alarm_flag_d = a2_fire ||
		(second_alarm_flag_q && !clr_a2 && !auto_clear);

	// Flags and match history
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			first_alarm_flag_q <= 1'b0;
			second_alarm_flag_q <= 1'b0;
			a1_prev_q <= 1'b0;
			a2_prev_q <= 1'b0;
		end else begin
			first_alarm_flag_q <= first_alarm_flag_d;
			second_alarm_flag_q <= second_alarm_flag_d;
			if (time_tick) begin
				a1_prev_q <= a1_match;
			end
			if (a2_eval) begin
				a2_prev_q <= a2_match;
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Frequency output is not modelled: pin released unless alarm one is on and flagged with its pin interrupt enabled
	wire irq_drive = intctl_q[rtcal_pkg::IC_A1E_BIT] &&
		intctl_q[rtcal_pkg::IC_PIN_INTERRUPT_SELECT_BIT] && alm1_on &&
		first_alarm_flag_q;
	assign interrupt_or_clock_out_pin_out = 1'b0;
	assign interrupt_or_clock_out_pin_oe_n = !irq_drive;
	assign sda_out = 1'b0;
	assign sda_oe_n = !drive_q;
	assign first_alarm_flag = first_alarm_flag_q;
	assign second_alarm_flag = second_alarm_flag_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	irq_pin_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
		a1_fire && intctl_q[rtcal_pkg::IC_A1E_BIT] &&
		intctl_q[rtcal_pkg::IC_PIN_INTERRUPT_SELECT_BIT] |=>
		!interrupt_or_clock_out_pin_oe_n)
		else $error("interrupt pin not pulled after alarm one");

	a1_every_sec_a: assert property (@(posedge mclk) disable iff (!rst_n)
		time_tick && alm1_on && a1_en == '0 |=> first_alarm_flag)
		else $error("alarm one missed a per-second trigger");

	a1_flag_cause_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(first_alarm_flag) |-> $past(time_tick && alm1_on))
		else $error("alarm one flag rose without a clock update");

	a2_minute_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(second_alarm_flag) |-> $past(time_tick) &&
		$past(time_second[6:0]) == rtcal_pkg::SECOND_ZERO)
		else $error("alarm two flag rose off the minute");

	sda_powerup_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!powered |-> sda_oe_n && state_q == rtcal_pkg::ST_IDLE)
		else $error("data line active during power-up");

	sda_low_clock_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(sda_oe_n) |->
		$past(!scl_sync_q || stop_det || start_det))
		else $error("data line moved while clock high");

	write_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
		byte_done && state_q == rtcal_pkg::ST_WR && !start_det && !stop_det
		|=> !sda_oe_n [*1] ##1 ack_phase_q)
		else $error("write byte not acknowledged");

	ptr_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(wr_go || rd_load) && ptr_q == rtcal_pkg::ADDR_PTR_LAST |=>
		ptr_q == rtcal_pkg::ADDR_PTR_FIRST)
		else $error("pointer did not wrap to zero");

	auto_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		auto_clear && !a1_fire && !a2_fire |=>
		!first_alarm_flag && !second_alarm_flag)
		else $error("flags survived auto-clear");

endmodule : rtcal_slave

`default_nettype wire

// ==== rtcal_master.sv ====
// Behavioural two-wire bus master, the far side of the alarm block
// Assumes the bench resolves the data line with a pull-up
`timescale 1ns/100ps
`default_nettype none

module rtcal_master (
	output logic scl,
	output logic sda_oe_n,
	input wire logic sda
);
	// ************************************************************
	// Bus primitives
	// ************************************************************
	// Idle: both lines released; the clock stands still between frames
	initial begin
		scl = 1'b1;
		sda_oe_n = 1'b1;
	end

	// One bit; data moves only while the clock is low
	task automatic clk_bit(input logic b, output logic r);
		sda_oe_n = b;
		#40 scl = 1'b1;
		#40 r = sda;
		#40 scl = 1'b0;
		#40;
	endtask : clk_bit

	// Data falls while the clock is high; also serves as a repeat
	task automatic start;
		sda_oe_n = 1'b1;
		#40 scl = 1'b1;
		#40 sda_oe_n = 1'b0;
		#40 scl = 1'b0;
		#40;
	endtask : start

	// Data rises while the clock is high, then the bus rests
	task automatic stop;
		sda_oe_n = 1'b0;
		#40 scl = 1'b1;
		#40 sda_oe_n = 1'b1;
		#80;
	endtask : stop

	// Byte out, top bit first, then release for the acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], r);
		end
		clk_bit(1'b1, r);
		ack = ~r;
	endtask : wbyte

	// Byte in; acknowledging asks for more, releasing ends the read
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			d[i] = r;
		end
		clk_bit(~more, r);
	endtask : rbyte
endmodule : rtcal_master
`default_nettype wire

// ==== rtcal_slave_tb.sv ====
// Self-checking bench for the alarm block and its two-wire port
// Assumes the partner master model makes the link clock
`timescale 1ns/100ps
`default_nettype none

module rtcal_slave_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic t_tick = 1'b0;
	// Clock fields: second, minute, hour, date, month, weekday
	logic [7:0] t_f [6] = '{8'h42, 8'h30, 8'h11, 8'h01, 8'h01, 8'h00};
	logic [7:0] bb [16];
	logic scl, m_oe_n, s_out, s_oe_n, irq_out, irq_oe_n, f1, f2, a;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	// Pull-ups: a line is low only while some party pulls it
	wire sda = (m_oe_n !== 1'b0) && (s_oe_n !== 1'b0 || s_out === 1'b1);
	wire irq_line = irq_oe_n !== 1'b0 || irq_out === 1'b1;

	rtcal_slave #(.DEV_ID(rtcal_pkg::DEVICE_ID), .POWERUP_CYCLES(4))
		rtcal_slave_i (.mclk(mclk), .rst_n(rst_n), .scl_in(scl),
		.sda_in(sda), .sda_out(s_out), .sda_oe_n(s_oe_n),
		.interrupt_or_clock_out_pin_out(irq_out),
		.interrupt_or_clock_out_pin_oe_n(irq_oe_n),
		.time_tick(t_tick), .time_second(t_f[0]), .time_minute(t_f[1]),
		.time_hour(t_f[2]), .time_date(t_f[3]), .time_month(t_f[4]),
		.time_weekday(t_f[5]), .first_alarm_flag(f1),
		.second_alarm_flag(f2));
	rtcal_master rtcal_master_i (.scl(scl), .sda_oe_n(m_oe_n), .sda(sda));

	// ************************************************************
	// Clock, timeout and shared tasks
	// ************************************************************
	always #5 mclk = ~mclk;

	// A hang counts as a mismatch and ends the run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// Every byte sent through this task must be acknowledged
	task automatic sendb(input logic [7:0] d);
		rtcal_master_i.wbyte(d, a);
		check(8'(a), 8'h01);
	endtask : sendb

	task automatic wr(input logic [7:0] adr, input int n);
		rtcal_master_i.start();
		sendb({rtcal_pkg::DEVICE_ID, 1'b0});
		sendb(adr);
		for (int i = 0; i < n; i++) begin
			sendb(bb[i]);
		end
		rtcal_master_i.stop();
	endtask : wr

	task automatic rd(input logic [7:0] adr, input int n);
		rtcal_master_i.start();
		sendb({rtcal_pkg::DEVICE_ID, 1'b0});
		sendb(adr);
		rtcal_master_i.start();
		sendb({rtcal_pkg::DEVICE_ID, 1'b1});
		for (int i = 0; i < n; i++) begin
			rtcal_master_i.rbyte(i < n - 1, bb[i]);
		end
		rtcal_master_i.stop();
	endtask : rd

	// Fields settle one edge before the one-cycle update strobe
	task automatic tick(input logic [7:0] s, m, h, d, w);
		@(posedge mclk);
		t_f <= '{s, m, h, d, 8'h01, w};
		@(posedge mclk);
		t_tick <= 1'b1;
		@(posedge mclk);
		t_tick <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask : tick

	task automatic put(input logic [7:0] adr, input logic [7:0] v);
		bb[0] = v;
		wr(adr, 1);
	endtask : put

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic s_regs;
		check(8'({sda, s_oe_n, irq_line, f1, f2}), 8'h1c);
		rtcal_master_i.start();
		rtcal_master_i.wbyte({rtcal_pkg::DEVICE_ID ^ 7'h01, 1'b0}, a);
		check(8'(a), 8'h00);
		rtcal_master_i.stop();
		for (int i = 0; i < 9; i++) begin
			bb[i] = 8'(8'h11 * i);
		end
		wr(rtcal_pkg::ADDR_ALARM_FIRST, 9);
		rd(rtcal_pkg::ADDR_ALARM_FIRST, 9);
		for (int i = 0; i < 9; i++) begin
			check(bb[i], 8'(8'h11 * i));
		end
		rd(rtcal_pkg::ADDR_PTR_LAST, 2);
		check(bb[0], 8'h00);
		check(bb[1], 8'h42);
		bb = '{default: 8'h00};
		wr(rtcal_pkg::ADDR_ALARM_FIRST, 9);
	endtask : s_regs

	task automatic s_alarm1;
		put(rtcal_pkg::ADDR_INTCTL, 8'h45);
		tick(8'h01, 8'h30, 8'h11, 8'h01, 8'h00);
		check(8'({f1, irq_line, f2}), 8'h04);
		put(rtcal_pkg::ADDR_STATUS, 8'h00);
		check(8'({f1, irq_line}), 8'h01);
		bb[0:2] = '{8'h95, 8'hb0, 8'h91};
		wr(rtcal_pkg::ADDR_ALARM_FIRST, 3);
		tick(8'h14, 8'h30, 8'h11, 8'h01, 8'h00);
		check(8'(f1), 8'h00);
		tick(8'h15, 8'h30, 8'h11, 8'h01, 8'h00);
		check(8'(f1), 8'h01);
		put(rtcal_pkg::ADDR_STATUS, 8'h00);
		tick(8'h15, 8'h30, 8'h11, 8'h01, 8'h00);
		check(8'(f1), 8'h00);
		tick(8'h15, 8'h30, 8'h51, 8'h01, 8'h00);
		check(8'(f1), 8'h00);
		tick(8'h15, 8'h30, 8'h11, 8'h01, 8'h00);
		check(8'({f1, irq_line}), 8'h02);
	endtask : s_alarm1

	// Alarm one is switched off here so only the second flag moves
	task automatic s_alarm2;
		put(rtcal_pkg::ADDR_STATUS, 8'h00);
		put(rtcal_pkg::ADDR_INTCTL, 8'h20);
		tick(8'h01, 8'h30, 8'h11, 8'h01, 8'h00);
		check(8'(f2), 8'h00);
		tick(8'h00, 8'h31, 8'h11, 8'h01, 8'h00);
		check(8'({f2, irq_line}), 8'h03);
		put(rtcal_pkg::ADDR_STATUS, 8'h80);
		check(8'(f2), 8'h00);
		bb[0:2] = '{8'h00, 8'h00, 8'hc1};
		wr(8'h12, 3);
		tick(8'h00, 8'h30, 8'h11, 8'h01, 8'h02);
		check(8'(f2), 8'h00);
		tick(8'h00, 8'h30, 8'h11, 8'h02, 8'h01);
		check(8'(f2), 8'h01);
		rd(rtcal_pkg::ADDR_STATUS, 1);
		check(bb[0], 8'h82);
		check(8'(f2), 8'h00);
		// Date mode: weekday 2 would match if the selector were ignored
		put(rtcal_pkg::ADDR_ALARM_LAST, 8'h82);
		tick(8'h00, 8'h30, 8'h11, 8'h03, 8'h02);
		check(8'(f2), 8'h00);
		tick(8'h00, 8'h30, 8'h11, 8'h02, 8'h03);
		check(8'(f2), 8'h01);
	endtask : s_alarm2

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (20) @(posedge mclk);
		s_regs();
		s_alarm1();
		s_alarm2();
		wrap_up();
	end
endmodule : rtcal_slave_tb
`default_nettype wire
